// File: rtl/uaf_regs.svh
// Register offsets, field positions, reset values and sampling counts of the filtered serial port
`ifndef UAF_REGS_SVH
`define UAF_REGS_SVH

// Register offsets on the 3-bit register port
`define UAF_OFS_DATA        3'h0
`define UAF_OFS_CSA         3'h1
`define UAF_OFS_CSB         3'h2
`define UAF_OFS_CSC         3'h3
`define UAF_OFS_BAUD_LO     3'h4
`define UAF_OFS_BAUD_HI     3'h5

// Control/status A fields
`define UAF_CSA_RXC         7
`define UAF_CSA_TXC         6
`define UAF_CSA_TX_BUFFER_EMPTY_FLAG        5
`define UAF_CSA_DBL         1
`define UAF_CSA_MPCF        0

// Control B fields
`define UAF_CSB_RXEN        4
`define UAF_CSB_TXEN        3
`define UAF_CSB_CSZ2        2
`define UAF_CSB_RX9         1
`define UAF_CSB_TX9         0

// Control C fields
`define UAF_CSC_STOP2       3
`define UAF_CSC_CSZ_HI      2
`define UAF_CSC_CSZ_LO      1

// Reset values
`define UAF_RST_CSZ         3'h3
`define UAF_RST_BAUD        12'h000

// Character size code for nine data bits
`define UAF_CSZ_NINE        3'h7

// Samples per bit and first voting sample, normal and double speed
`define UAF_SAMP_NORMAL     5'h10
`define UAF_SAMP_DOUBLE     5'h08
`define UAF_VOTE_NORMAL     5'h08
`define UAF_VOTE_DOUBLE     5'h04

// Receive FIFO depth
`define UAF_FIFO_DEPTH      2'h2

`endif

// File: rtl/uaf_pkg.sv
// Types and shared decode functions of the filtered serial port
`include "uaf_regs.svh"

package uaf_pkg;

   typedef enum logic [1:0] {UAF_IDLE, UAF_START, UAF_DATA, UAF_STOP} uaf_state_e;

   // Number of data bits for a character size code; reserved codes act as eight
   function automatic logic [3:0] uaf_char_bits(input logic [2:0] code);
      logic [3:0] bits;
      bits = 4'h8;
      case (code)
         3'h0: bits = 4'h5;
         3'h1: bits = 4'h6;
         3'h2: bits = 4'h7;
         3'h3: bits = 4'h8;
         `UAF_CSZ_NINE: bits = 4'h9;
         default: bits = 4'h8;
      endcase
      return bits;
   endfunction

   // Samples per bit for the selected speed
   function automatic logic [4:0] uaf_samp_per_bit(input logic dbl);
      return dbl ? `UAF_SAMP_DOUBLE : `UAF_SAMP_NORMAL;
   endfunction

   // Two of three voting
   function automatic logic uaf_majority(input logic [1:0] a, input logic b);
      return (a[1] & a[0]) | (a[1] & b) | (a[0] & b);
   endfunction

endpackage

// File: rtl/uaf_rx.sv
// Oversampling serial receiver with three-sample voting and frame-type recovery
`timescale 1ns/1ps
`default_nettype none

module uaf_rx (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   // Configuration
   input  wire logic             rx_en,
   input  wire logic             dbl,
   input  wire logic [2:0]       char_size_sel,
   input  wire logic             samp_tick,
   // Serial line
   input  wire logic             rxd,
   // Received frame
   output logic                  frame_valid,
   output logic [8:0]            frame_data,
   output logic                  frame_type
);
   import uaf_pkg::*;

   typedef struct packed {
      uaf_state_e st;
      logic [4:0] cnt;
      logic [3:0] idx;
      logic [1:0] vote;
      logic [8:0] data;
      logic       valid;
      logic       ftype;
   } uaf_rx_s;

   uaf_rx_s    st_r;
   uaf_rx_s    st_nxt;
   logic [4:0] smax;
   logic [4:0] sf;
   logic [4:0] sf1;
   logic [4:0] sf2;
   logic [3:0] nb;
   logic       bitv;

   // Sample window follows the speed setting
   assign smax = uaf_samp_per_bit(dbl);
   assign sf   = dbl ? `UAF_VOTE_DOUBLE : `UAF_VOTE_NORMAL;
   assign sf1  = sf + 5'h01;
   assign sf2  = sf + 5'h02;
   assign nb   = uaf_char_bits(char_size_sel);
   assign bitv = uaf_majority(st_r.vote, rxd);

   // Bit recovery; stop bit ends the frame right after its vote so the next start is not missed
   always_comb begin
      st_nxt = st_r;
      st_nxt.valid = 1'b0;
      if (!rx_en) begin
         st_nxt.st = UAF_IDLE;
      end else if (samp_tick) begin
         case (st_r.st)
            UAF_IDLE: begin
               if (!rxd) begin
                  st_nxt.st   = UAF_START;
                  // The edge that first sees low is sample 1, so the count resumes at 2
                  st_nxt.cnt  = 5'h02;
                  st_nxt.idx  = 4'h0;
                  st_nxt.data = 9'h000;
               end
            end
            default: begin
               if (st_r.cnt == sf || st_r.cnt == sf1) begin
                  st_nxt.vote = {st_r.vote[0], rxd};
               end
               if (st_r.cnt == sf2) begin
                  case (st_r.st)
                     UAF_START: begin
                        if (bitv) begin
                           st_nxt.st = UAF_IDLE;                          // Noise spike
                        end
                     end
                     UAF_DATA: begin
                        st_nxt.data[st_r.idx] = bitv;
                     end
                     default: begin
                        st_nxt.st    = UAF_IDLE;
                        st_nxt.valid = 1'b1;
                        // Ninth bit or first stop bit marks an address frame
                        st_nxt.ftype = (nb == 4'h9) ? st_r.data[8] : bitv;
                     end
                  endcase
               end
               if (st_r.cnt == smax) begin
                  st_nxt.cnt = 5'h01;
                  if (st_r.st == UAF_START) begin
                     st_nxt.st = UAF_DATA;
                  end else if (st_r.st == UAF_DATA) begin
                     if (st_r.idx == nb - 4'h1) begin
                        st_nxt.st = UAF_STOP;
                     end else begin
                        st_nxt.idx = st_r.idx + 4'h1;
                     end
                  end
               end else begin
                  st_nxt.cnt = st_r.cnt + 5'h01;
               end
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_r <= '{st: UAF_IDLE, cnt: 5'h00, idx: 4'h0, vote: 2'h3,
                   data: 9'h000, valid: 1'b0, ftype: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign frame_valid = st_r.valid;
   assign frame_data  = st_r.data;
   assign frame_type  = st_r.ftype;

endmodule

`default_nettype wire

// File: rtl/uaf_tx.sv
// Serial transmitter shifting 5 to 9 data bits with one or two stop bits
`timescale 1ns/1ps
`default_nettype none

module uaf_tx (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   // Configuration
   input  wire logic             dbl,
   input  wire logic [2:0]       char_size_sel,
   input  wire logic             stop_bits_sel,
   input  wire logic             samp_tick,
   // Load from the transmit buffer
   input  wire logic             load,
   input  wire logic [8:0]       load_data,
   output logic                  busy,
   output logic                  done,
   // Serial line
   output logic                  txd
);
   import uaf_pkg::*;

   typedef struct packed {
      uaf_state_e st;
      logic [4:0] cnt;
      logic [3:0] idx;
      logic [8:0] sh;
      logic       second;
      logic       line;
      logic       done;
   } uaf_tx_s;

   uaf_tx_s    st_r;
   uaf_tx_s    st_nxt;
   logic [4:0] smax;
   logic [3:0] nb;

   assign smax = uaf_samp_per_bit(dbl);
   assign nb   = uaf_char_bits(char_size_sel);

   // Only the low nb bits leave the shifter, so unused upper bits are ignored
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      case (st_r.st)
         UAF_IDLE: begin
            st_nxt.line = 1'b1;
            if (load) begin
               st_nxt.st     = UAF_START;
               st_nxt.sh     = load_data;
               st_nxt.cnt    = 5'h01;
               st_nxt.idx    = 4'h0;
               st_nxt.second = 1'b0;
               st_nxt.line   = 1'b0;
            end
         end
         default: begin
            if (samp_tick) begin
               if (st_r.cnt == smax) begin
                  st_nxt.cnt = 5'h01;
                  case (st_r.st)
                     UAF_START: begin
                        st_nxt.st   = UAF_DATA;
                        st_nxt.line = st_r.sh[0];
                     end
                     UAF_DATA: begin
                        if (st_r.idx == nb - 4'h1) begin
                           st_nxt.st   = UAF_STOP;
                           st_nxt.line = 1'b1;
                        end else begin
                           st_nxt.idx  = st_r.idx + 4'h1;
                           st_nxt.sh   = {1'b0, st_r.sh[8:1]};
                           st_nxt.line = st_r.sh[1];
                        end
                     end
                     default: begin
                        if (stop_bits_sel && !st_r.second) begin
                           st_nxt.second = 1'b1;
                        end else begin
                           st_nxt.st   = UAF_IDLE;
                           st_nxt.done = 1'b1;
                        end
                     end
                  endcase
               end else begin
                  st_nxt.cnt = st_r.cnt + 5'h01;
               end
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_r <= '{st: UAF_IDLE, cnt: 5'h00, idx: 4'h0, sh: 9'h000,
                   second: 1'b0, line: 1'b1, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy = (st_r.st != UAF_IDLE);
   assign done = st_r.done;
   assign txd  = st_r.line;

endmodule

`default_nettype wire

// File: rtl/uaf_top.sv
// Serial port with multi-processor address filter and shared data register
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Filter on: drop non-address frames entirely
// - Transmitter ignores the filter enable
// - 5-8 bit frames: first stop bit types
// - 9-bit frames: ninth bit types frame
// - Type one is address, zero data
// - Accepted address sets receive-complete normally
// - One character size for both directions
// - Data port: write transmit, read receive
// - Short characters: upper bits ignored/zero
// - Write while buffer full is ignored
// - Buffer moves to empty shifter, sent
// - Receive buffer is two-entry FIFO
// - 16 samples normal, 8 double speed
// - Vote from sample 8 or 4
// - Three centre samples majority vote
// - Filter enable is bit 0, reset 0
module uaf_top #(
   parameter int BAUD_W = 12
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   // Register port
   input  wire logic [2:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [7:0]            reg_rdata,
   // Serial pins
   input  wire logic             rxd,
   output logic                  txd,
   output logic                  txd_oe
);
   import uaf_pkg::*;

   typedef struct packed {
      logic              tx_complete_flag;
      logic              dbl;
      logic              mpf;
      logic              rx_en;
      logic              tx_en;
      logic              tx9;
      logic              stop2;
      logic [2:0]        csz;
      logic [BAUD_W-1:0] baud;
      logic [BAUD_W-1:0] bcnt;
      logic [8:0]        tx_data_buffer;
      logic              txb_full;
      logic [1:0][8:0]   fifo;
      logic [1:0]        fcnt;
      logic [7:0]        rdata;
   } uaf_top_s;

   uaf_top_s   st_r;
   uaf_top_s   st_nxt;
   logic       samp_tick;
   logic       rx_valid;
   logic [8:0] rx_data;
   logic       rx_type;
   logic       tx_busy;
   logic       tx_done;
   logic       tx_load;
   logic       wr_data;
   logic       rd_data;
   logic       wr_csa;
   logic       accept;
   logic [1:0] fill;
   logic [8:0] head;

   // Register port decode
   assign wr_data = reg_wr && (reg_addr == `UAF_OFS_DATA);
   assign rd_data = reg_rd && (reg_addr == `UAF_OFS_DATA);
   assign wr_csa  = reg_wr && (reg_addr == `UAF_OFS_CSA);
   assign head    = st_r.fifo[0];

   // Sample clock: one tick every baud+1 system cycles, shared by both directions
   assign samp_tick = (st_r.bcnt == '0);

   // Filter only looks at received frames; the transmit path never sees it
   assign accept  = rx_valid && (!st_r.mpf || rx_type);
   assign tx_load = st_r.tx_en && st_r.txb_full && !tx_busy;

   // Register, FIFO and buffer update
   always_comb begin
      st_nxt = st_r;
      fill   = st_r.fcnt;
      st_nxt.rdata = 8'h00;

      // Baud counter
      st_nxt.bcnt = samp_tick ? st_r.baud : st_r.bcnt - 1'b1;

      // Receive FIFO: a read pops first so a frame landing in the same cycle fits
      if (rd_data && st_r.fcnt != 2'h0) begin
         st_nxt.fifo[0] = st_r.fifo[1];
         fill = st_r.fcnt - 2'h1;
      end
      if (accept && fill < `UAF_FIFO_DEPTH) begin
         st_nxt.fifo[fill[0]] = rx_data;
         fill = fill + 2'h1;
      end
      st_nxt.fcnt = fill;

      // Transmit buffer hand-off to the shifter
      if (tx_load) begin
         st_nxt.txb_full = 1'b0;
      end
      // Data writes land in the transmit buffer only while it is empty
      if (wr_data && !st_r.txb_full) begin
         st_nxt.tx_data_buffer      = {st_r.tx9, reg_wdata};
         st_nxt.txb_full = 1'b1;
      end

      // Control writes
      if (wr_csa) begin
         st_nxt.dbl = reg_wdata[`UAF_CSA_DBL];
         st_nxt.mpf = reg_wdata[`UAF_CSA_MPCF];
         if (reg_wdata[`UAF_CSA_TXC]) begin
            st_nxt.tx_complete_flag = 1'b0;
         end
      end
      if (reg_wr && reg_addr == `UAF_OFS_CSB) begin
         st_nxt.rx_en  = reg_wdata[`UAF_CSB_RXEN];
         st_nxt.tx_en  = reg_wdata[`UAF_CSB_TXEN];
         st_nxt.csz[2] = reg_wdata[`UAF_CSB_CSZ2];
         st_nxt.tx9    = reg_wdata[`UAF_CSB_TX9];
      end
      if (reg_wr && reg_addr == `UAF_OFS_CSC) begin
         st_nxt.stop2    = reg_wdata[`UAF_CSC_STOP2];
         st_nxt.csz[1:0] = reg_wdata[`UAF_CSC_CSZ_HI:`UAF_CSC_CSZ_LO];
      end
      if (reg_wr && reg_addr == `UAF_OFS_BAUD_LO) begin
         st_nxt.baud[7:0] = reg_wdata;
      end
      if (reg_wr && reg_addr == `UAF_OFS_BAUD_HI) begin
         st_nxt.baud[BAUD_W-1:8] = reg_wdata[BAUD_W-9:0];
      end

      // Transmit complete sets after the write-one clear so a fresh event is kept
      if (tx_done && !st_r.txb_full) begin
         st_nxt.tx_complete_flag = 1'b1;
      end

      // Disabling the receiver empties the FIFO
      if (!st_r.rx_en) begin
         st_nxt.fcnt = 2'h0;
      end

      // Read data stands only in the cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            `UAF_OFS_DATA: begin
               st_nxt.rdata = (st_r.fcnt != 2'h0) ? head[7:0] : 8'h00;
            end
            `UAF_OFS_CSA: begin
               st_nxt.rdata[`UAF_CSA_RXC]  = (st_r.fcnt != 2'h0);
               st_nxt.rdata[`UAF_CSA_TXC]  = st_r.tx_complete_flag;
               st_nxt.rdata[`UAF_CSA_TX_BUFFER_EMPTY_FLAG] = !st_r.txb_full;
               st_nxt.rdata[`UAF_CSA_DBL]  = st_r.dbl;
               st_nxt.rdata[`UAF_CSA_MPCF] = st_r.mpf;
            end
            `UAF_OFS_CSB: begin
               st_nxt.rdata[`UAF_CSB_RXEN] = st_r.rx_en;
               st_nxt.rdata[`UAF_CSB_TXEN] = st_r.tx_en;
               st_nxt.rdata[`UAF_CSB_CSZ2] = st_r.csz[2];
               st_nxt.rdata[`UAF_CSB_RX9]  = (st_r.fcnt != 2'h0) && head[8];
               st_nxt.rdata[`UAF_CSB_TX9]  = st_r.tx9;
            end
            `UAF_OFS_CSC: begin
               st_nxt.rdata[`UAF_CSC_STOP2] = st_r.stop2;
               st_nxt.rdata[`UAF_CSC_CSZ_HI:`UAF_CSC_CSZ_LO] = st_r.csz[1:0];
            end
            `UAF_OFS_BAUD_LO: begin
               st_nxt.rdata = st_r.baud[7:0];
            end
            `UAF_OFS_BAUD_HI: begin
               st_nxt.rdata[BAUD_W-9:0] = st_r.baud[BAUD_W-1:8];
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_r          <= '0;
         st_r.csz      <= `UAF_RST_CSZ;
         st_r.baud     <= `UAF_RST_BAUD;
         st_r.bcnt     <= `UAF_RST_BAUD;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Receiver
   uaf_rx u_rx (
      .clk_sys       (clk_sys),
      .resetn        (resetn),
      .rx_en         (st_r.rx_en),
      .dbl           (st_r.dbl),
      .char_size_sel (st_r.csz),
      .samp_tick     (samp_tick),
      .rxd           (rxd),
      .frame_valid   (rx_valid),
      .frame_data    (rx_data),
      .frame_type    (rx_type)
   );

   // Transmitter
   uaf_tx u_tx (
      .clk_sys       (clk_sys),
      .resetn        (resetn),
      .dbl           (st_r.dbl),
      .char_size_sel (st_r.csz),
      .stop_bits_sel (st_r.stop2),
      .samp_tick     (samp_tick),
      .load          (tx_load),
      .load_data     (st_r.tx_data_buffer),
      .busy          (tx_busy),
      .done          (tx_done),
      .txd           (txd)
   );

   // Pin stays driven while a character is shifting or waiting in the buffer, even after the enable drops stops the buffer load
   assign txd_oe    = st_r.tx_en || tx_busy || st_r.txb_full;
   assign reg_rdata = st_r.rdata;

endmodule

`default_nettype wire

// File: sim/uaf_top_checker.sv
// Port-level assertions of the filtered serial port
`timescale 1ns/1ps
`default_nettype none
`include "uaf_regs.svh"
module uaf_top_checker #(
   parameter int BAUD_W = 12
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       resetn,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Serial pins
   input wire logic       rxd,
   input wire logic       txd,
   input wire logic       txd_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // Shadows of written control bits; the receive FIFO is not modelled here
   logic       fen_r;
   logic       dbl_r;
   logic       txen_r;
   logic       csz2_r;
   logic [1:0] cszl_r;
   logic [5:0] idle_r;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         fen_r  <= 1'b0;
         dbl_r  <= 1'b0;
         txen_r <= 1'b0;
         csz2_r <= 1'b0;
         cszl_r <= 2'h3;
         idle_r <= 6'h00;
      end else begin
         if (reg_wr && reg_addr == `UAF_OFS_CSA) begin
            fen_r <= reg_wdata[`UAF_CSA_MPCF];
            dbl_r <= reg_wdata[`UAF_CSA_DBL];
         end
         if (reg_wr && reg_addr == `UAF_OFS_CSB) begin
            txen_r <= reg_wdata[`UAF_CSB_TXEN];
            csz2_r <= reg_wdata[`UAF_CSB_CSZ2];
         end
         if (reg_wr && reg_addr == `UAF_OFS_CSC) begin
            cszl_r <= reg_wdata[2:1];
         end
         // Saturates only after a gap longer than two normal stop bits
         idle_r <= !txd ? 6'h00 : (idle_r == 6'h3F) ? idle_r : idle_r + 6'h01;
      end
   end

   // Data write onto a long idle line, then the start bit
   sequence s_data_wr_idle;
      txen_r && idle_r == 6'h3F && reg_wr && reg_addr == `UAF_OFS_DATA;
   endsequence
   sequence s_start_bit;
      ##[1:3] !txd;
   endsequence

   AST_TX_START: assert property (s_data_wr_idle |-> s_start_bit)
      else $error("data write on idle line started no frame");
   AST_START_LEN: assert property ($fell(txd) |-> (!txd)[*6])
      else $error("start bit too short");
   AST_RDATA_ZERO: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read answer cycle");
   AST_UNMAPPED: assert property (reg_rd && reg_addr > `UAF_OFS_BAUD_HI |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_FEN_RB: assert property (reg_rd && reg_addr == `UAF_OFS_CSA
      |=> reg_rdata[1:0] == {$past(dbl_r), $past(fen_r)})
      else $error("filter enable read-back wrong");
   AST_TX_BUFFER_EMPTY_FLAG_IDLE: assert property (reg_rd && reg_addr == `UAF_OFS_CSA && !txd_oe
      |=> reg_rdata[`UAF_CSA_TX_BUFFER_EMPTY_FLAG])
      else $error("buffer empty flag low while transmitter idle");
   AST_CSB_RB: assert property (reg_rd && reg_addr == `UAF_OFS_CSB
      |=> reg_rdata[3:2] == {$past(txen_r), $past(csz2_r)})
      else $error("control B read-back wrong");
   AST_CSC_RB: assert property (reg_rd && reg_addr == `UAF_OFS_CSC
      |=> reg_rdata[2:1] == $past(cszl_r))
      else $error("character size read-back wrong");
   AST_OE_TXEN: assert property (txen_r |-> txd_oe)
      else $error("output enable low with transmitter on");
   AST_TXD_IDLE: assert property (!txd_oe |-> txd)
      else $error("undriven transmit line not high");
endmodule
`default_nettype wire

// File: sim/uaf_peer.sv
// Remote serial station: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module uaf_peer (
   // Clock
   input  wire logic clk_sys,
   // Serial lines
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'b1;

   // Start, data LSB first, type as first stop, then a closing stop only when short
   task automatic send(input logic [8:0] d, input int nb, input logic typ, input int spb);
      int n;
      n = (nb < 9) ? nb + 3 : nb + 2;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         rxd <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? typ : 1'b1;
         repeat (spb - 1) @(posedge clk_sys);
      end
   endtask

   // Short low glitch, far shorter than a bit
   task automatic spike(input int len);
      @(posedge clk_sys);
      rxd <= 1'b0;
      repeat (len) @(posedge clk_sys);
      rxd <= 1'b1;
   endtask

   // Samples bit centres; returns after the first stop bit centre
   task automatic recv(input int nb, input int spb, output logic [8:0] d, output logic stp);
      d = 9'h000;
      @(negedge txd);
      repeat (spb / 2) @(posedge clk_sys);
      for (int i = 0; i < nb; i++) begin
         repeat (spb) @(posedge clk_sys);
         d[i] = txd;
      end
      repeat (spb) @(posedge clk_sys);
      stp = txd;
   endtask
endmodule
`default_nettype wire

// File: sim/uaf_top_test.sv
// Self-checking bench of the filtered serial port
`timescale 1ns/1ps
`default_nettype none
`include "uaf_regs.svh"
module uaf_top_test;
   logic       clk_sys;
   logic       resetn;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       rxd;
   logic       txd;
   logic       txd_oe;
   logic [7:0] rv;
   logic [8:0] fr;
   logic       stp;
   int         failures;
   int         n_tests;
   logic [7:0] rst_v [8] = '{8'h00, 8'h20, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};

   uaf_top #(.BAUD_W(12)) dut_u (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rxd(rxd), .txd(txd), .txd_oe(txd_oe));
   uaf_peer peer_u (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // One-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read data is only valid in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      rd(a, rv);
      chk8(rv, e);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      #800000;
      failures++;
      give_verdict();
   end

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      failures = 0;
      n_tests = 0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      foreach (rst_v[i]) rchk(i[2:0], rst_v[i]);
      $display("reset values done");
      // Plain reception, then read empties the buffer
      wr(`UAF_OFS_CSB, 8'h18);
      peer_u.send(9'h0A5, 8, 1'b1, 16);
      rchk(`UAF_OFS_CSA, 8'hA0);
      rchk(`UAF_OFS_DATA, 8'hA5);
      rchk(`UAF_OFS_CSA, 8'h20);
      // Three frames into a two-entry buffer, oldest first
      peer_u.send(9'h011, 8, 1'b1, 16);
      peer_u.send(9'h022, 8, 1'b1, 16);
      peer_u.send(9'h033, 8, 1'b1, 16);
      rchk(`UAF_OFS_DATA, 8'h11);
      rchk(`UAF_OFS_DATA, 8'h22);
      rchk(`UAF_OFS_DATA, 8'h00);
      $display("receive and buffer done");
      // Filter on, 8-bit frames typed by first stop bit
      wr(`UAF_OFS_CSA, 8'h01);
      peer_u.send(9'h066, 8, 1'b0, 16);
      peer_u.send(9'h05A, 8, 1'b1, 16);
      rchk(`UAF_OFS_CSA, 8'hA1);
      rchk(`UAF_OFS_DATA, 8'h5A);
      rchk(`UAF_OFS_CSA, 8'h21);
      // A glitch that is gone before the voting samples is no start bit
      peer_u.spike(4);
      repeat (200) @(posedge clk_sys);
      rchk(`UAF_OFS_CSA, 8'h21);
      $display("filter 8-bit done");
      // Nine-bit frames typed by the ninth bit
      wr(`UAF_OFS_CSB, 8'h1C);
      peer_u.send(9'h0C3, 9, 1'b1, 16);
      peer_u.send(9'h1A7, 9, 1'b1, 16);
      rchk(`UAF_OFS_CSB, 8'h1E);
      rchk(`UAF_OFS_DATA, 8'hA7);
      rchk(`UAF_OFS_CSB, 8'h1C);
      wr(`UAF_OFS_CSA, 8'h00);
      peer_u.send(9'h0C3, 9, 1'b1, 16);
      rchk(`UAF_OFS_DATA, 8'hC3);
      $display("filter 9-bit done");
      // Five-bit size shared by both directions, filter on
      wr(`UAF_OFS_CSB, 8'h18);
      wr(`UAF_OFS_CSC, 8'h00);
      wr(`UAF_OFS_CSA, 8'h01);
      peer_u.send(9'h015, 5, 1'b1, 16);
      rchk(`UAF_OFS_DATA, 8'h15);
      fork
         peer_u.recv(5, 16, fr, stp);
         wr(`UAF_OFS_DATA, 8'h55);
      join
      chk8({3'h0, fr[4:0]}, 8'h15);
      chk8({7'h00, stp}, 8'h01);
      $display("short characters done");
      // Speed must not change while the short frame's stop bit is still going out
      repeat (40) @(posedge clk_sys);
      // Double speed: two frames sent, a third write while full is dropped
      wr(`UAF_OFS_CSC, 8'h06);
      wr(`UAF_OFS_CSA, 8'h42);
      fork
         begin
            peer_u.recv(8, 8, fr, stp);
            chk8(fr[7:0], 8'h3C);
            peer_u.recv(8, 8, fr, stp);
            chk8(fr[7:0], 8'hC3);
         end
         begin
            wr(`UAF_OFS_DATA, 8'h3C);
            repeat (3) @(posedge clk_sys);
            wr(`UAF_OFS_DATA, 8'hC3);
            wr(`UAF_OFS_DATA, 8'h99);
         end
      join
      repeat (20) @(posedge clk_sys);
      rchk(`UAF_OFS_CSA, 8'h62);
      repeat (200) begin
         @(posedge clk_sys);
         chk8({7'h00, txd}, 8'h01);
      end
      peer_u.send(9'h096, 8, 1'b1, 8);
      rchk(`UAF_OFS_DATA, 8'h96);
      $display("double speed done");
      give_verdict();
   end
endmodule

bind uaf_top uaf_top_checker #(.BAUD_W(BAUD_W)) chk_u (.clk_sys(clk_sys), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .txd_oe(txd_oe));
`default_nettype wire
